// ---- bench/lcdc_cmd_decoder_tb.sv ----
`timescale 1ns/10ps
module lcdc_cmd_decoder_tb;
  import lcdc_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       hw_reset_n = 1'b1;
  logic       wr_done, rd_done, cmd_data_select, ram_we, sleep, standby, ind_level, wv, wi;
  logic [7:0] wr_data, rd_data, ram_wdata, ram_col, ram_rdata, sav, b;
  logic [3:0] ram_page;
  logic [31:0] r;
  lcdc_cfg_t  cfg, e;
  logic [7:0] ram [4096];
  logic [7:0] xram [4096];
  int         bad_count = 0;
  int         comparisons = 0;

  always #2.5 clk = ~clk;
  assign ram_rdata = ram[{ram_page, ram_col}];
  always @(posedge clk) if (ram_we) ram[{ram_page, ram_col}] <= ram_wdata;

  lcdc_host_model host (.clk(clk), .wr_done(wr_done), .rd_done(rd_done), .cmd_data_select(cmd_data_select),
                        .wr_data(wr_data));
  lcdc_cmd_decoder #(.FAST_CYCLES(4), .SLOW_CYCLES(8)) uut (.clk(clk), .rst(rst), .hw_reset_n(hw_reset_n),
    .wr_done(wr_done), .rd_done(rd_done), .cmd_data_select(cmd_data_select), .wr_data(wr_data),
    .rd_data(rd_data), .ram_we(ram_we), .ram_wdata(ram_wdata), .ram_page(ram_page), .ram_col(ram_col),
    .ram_rdata(ram_rdata), .cfg(cfg), .sleep(sleep), .standby(standby), .ind_level(ind_level));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    comparisons++;
    if (x !== g)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic chk_all();
    #1;
    comparisons++;
    if (cfg !== e)
    begin
      bad_count++;
      $display("wrong value cfg expected %h seen %h", e, cfg);
    end
    chk("sleep", {7'h0, !e.disp_on && e.entire_on && !e.ind_on}, {7'h0, sleep});
    chk("standby", {7'h0, !e.disp_on && e.entire_on && e.ind_on}, {7'h0, standby});
  endtask : chk_all

  task automatic reset_exp();
    e = '0;
    e.contrast = 6'h20;
    wv = 1'b0;
    wi = 1'b0;
  endtask : reset_exp

  task automatic cmd(input logic [7:0] c);
    host.xfer(1'b1, 1'b0, c);
    if (wv) {wv, e.contrast} = {1'b0, c[5:0]};
    else if (wi) {wi, e.blink_mode} = {1'b0, c[1:0]};
    else casez (c)
      8'b1010_111?: e.disp_on = c[0];
      8'b01??_????: e.start_line = c[5:0];
      8'b1011_????: e.page = c[3:0];
      8'b0001_????: e.column[7:4] = c[3:0];
      8'b0000_????: e.column[3:0] = c[3:0];
      8'b1010_000?: e.seg_reverse = c[0];
      8'b1010_011?: e.invert = c[0];
      8'b1010_010?: e.entire_on = c[0];
      8'b1010_001?: e.bias_sel = c[0];
      8'he0: {e.rmw_active, sav} = {1'b1, e.column};
      8'hee: {e.rmw_active, e.column} = {1'b0, sav};
      8'he2: {e.start_line, e.page, e.column, e.rmw_active, e.test_mode, e.contrast} = {20'h0, 6'h20};
      8'b1100_????: e.com_reverse = c[3];
      8'b0010_1???: e.power_ctrl = c[2:0];
      8'b0010_0???: e.reg_ratio = c[2:0];
      8'h81: wv = 1'b1;
      8'b1010_110?: {e.ind_on, wi, e.blink_mode} = {c[0], c[0], c[0] ? e.blink_mode : 2'h0};
      8'hf0: e.test_mode = 1'b0;
      8'b1111_????: e.test_mode = 1'b1;
      default: ;
    endcase
    chk_all();
  endtask : cmd

  task automatic xs(input logic wr, input logic sel, input logic [7:0] d);
    host.xfer(wr, sel, d);
    #1;
    if (wr)
    begin
      chk("we", 8'h1, {7'h0, ram_we});
      chk("col", e.column, ram_col);
      chk("page", {4'h0, e.page}, {4'h0, ram_page});
      chk("wdat", d, ram_wdata);
      xram[{e.page, e.column}] = d;
      e.column++;
    end
    else if (sel)
    begin
      chk("rdat", xram[{e.page, e.column}], rd_data);
      if (!e.rmw_active) e.column++;
    end
    else chk("stat", {1'b0, e.seg_reverse, !e.disp_on, 5'h0}, rd_data);
    chk_all();
  endtask : xs

  task automatic pulse(input logic hw);
    @(posedge clk);
    if (hw) hw_reset_n <= 1'b0;
    else rst <= 1'b1;
    @(posedge clk);
    hw_reset_n <= 1'b1;
    rst <= 1'b0;
    reset_exp();
    chk_all();
  endtask : pulse

  task automatic blink(input logic [1:0] m);
    int t;
    int h;
    logic p;
    cmd(8'had);
    cmd({6'h2a, m});
    t = 0;
    h = 0;
    p = ind_level;
    repeat (48)
    begin
      @(posedge clk);
      #1;
      t += int'(ind_level != p);
      h += int'(ind_level);
      p = ind_level;
    end
    chk("toggle", m == 2'h1 ? 8'hc : m == 2'h2 ? 8'h6 : 8'h0, t[7:0]);
    chk("lit", m == 2'h3 ? 8'h30 : m == 2'h0 ? 8'h0 : 8'h18, h[7:0]);
  endtask : blink

  function automatic logic ok(input logic [7:0] c);
    return !(c[7:4] inside {4'h3, 4'hd} || (c[7:5] == 3'b100 && c != 8'h81) || c[7:2] == 6'h2a
             || (c[7:4] == 4'he && !(c inside {8'he0, 8'he2, 8'he3, 8'hee})));
  endfunction : ok

  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(33585));
    for (int i = 0; i < 4096; i++)
    begin
      ram[i] = 8'h00;
      xram[i] = 8'h00;
    end
    reset_exp();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    chk_all();
    cmd(8'hf7);
    pulse(1'b1);
    cmd(8'hfc);
    pulse(1'b0);
    cmd(8'hf3);
    cmd(8'he2);
    cmd(8'h81);
    cmd(8'he2);
    cmd(8'hae);
    cmd(8'ha5);
    for (int m = 0; m < 4; m++) blink(2'(m));
    cmd(8'hac);
    repeat (500)
    begin
      r = $urandom;
      b = r[7:0];
      if (wv || wi) cmd(b);
      else if (r[10:8] == 3'h0) xs(1'b1, 1'b1, b);
      else if (r[10:8] == 3'h1) xs(1'b0, r[11], b);
      else if (ok(b)) cmd(b);
      if (r[31:27] == 5'h0) cmd(8'hf0);
    end
    end_sim();
  end
endmodule : lcdc_cmd_decoder_tb

// ---- bench/lcdc_host_model.sv ----
`timescale 1ns/10ps
module lcdc_host_model (
  input  wire logic       clk,             // bus clock
  output logic            wr_done,         // write strobe pulse
  output logic            rd_done,         // read strobe pulse
  output logic            cmd_data_select, // 0 command, 1 data
  output logic [7:0]      wr_data          // host byte
);
  initial
  begin
    wr_done = 1'b0;
    rd_done = 1'b0;
    cmd_data_select = 1'b0;
    wr_data = 8'h5a;
  end

  // one strobe then a free cycle, so no strobe is set twice in one step
  task automatic xfer(input logic wr, input logic sel, input logic [7:0] b);
    @(posedge clk);
    wr_done         <= wr;
    rd_done         <= !wr;
    cmd_data_select <= sel;
    wr_data         <= b;
    @(posedge clk);
    wr_done         <= 1'b0;
    rd_done         <= 1'b0;
    cmd_data_select <= !sel;
    wr_data         <= ~b; // released bus must not look valid
  endtask : xfer
endmodule : lcdc_host_model

// ---- rtl/lcdc_cmd_decoder.sv ----
`timescale 1ns/10ps
`include "lcdc_regs.svh"
// How it works
// - upper nibble all ones, except F0, enters test mode
// - hardware reset or reset command exits test
// - byte F0 exits test mode
// - 1010111x switches panel drive on/off
// - 01 prefix loads displayed start line
// - 1011 prefix loads page address
// - 0001/0000 load column high/low nibble
// - status read: flags high, zeros low
// - data write stores, data read returns RAM
// - 1010000x sets segment direction
// - 1010011x sets pixel polarity
// - 1010010x forces all pixels on
// - 1010001x selects bias ratio
// - E0 starts read-modify-write, EE ends it
// - E2 performs software reset
// - 1100 with bit 3 sets common direction
// - 00101 prefix sets power circuits
// - 00100 prefix sets regulator ratio
// - 81 arms contrast, next byte stores it
// - 1010110x indicator; on takes blink byte
// - armed contrast blocks other commands
// - blink codes: off, fast, slow, steady
// - power save: sleep or standby by indicator
module lcdc_cmd_decoder
  import lcdc_pkg::*;
#(
  parameter int unsigned FAST_CYCLES = `LCDC_BLINK_FAST_MS * `LCDC_CLK_KHZ,
  parameter int unsigned SLOW_CYCLES = `LCDC_BLINK_SLOW_MS * `LCDC_CLK_KHZ
)
(
  input  wire logic             clk,             // 200 MHz clock
  input  wire logic             rst,             // sync reset, high
  input  wire logic             hw_reset_n,      // reset pin, low resets
  input  wire logic             wr_done,         // completed host write pulse
  input  wire logic             rd_done,         // completed host read pulse
  input  wire logic             cmd_data_select, // 0 command, 1 data
  input  wire logic [7:0]       wr_data,         // host write byte
  output logic      [7:0]       rd_data,         // host read byte
  output logic                  ram_we,          // display RAM write pulse
  output logic      [7:0]       ram_wdata,       // display RAM write byte
  output logic      [3:0]       ram_page,        // display RAM page
  output logic      [7:0]       ram_col,         // display RAM column
  input  wire logic [7:0]       ram_rdata,       // display RAM byte at address
  output lcdc_pkg::lcdc_cfg_t   cfg,             // decoded settings
  output logic                  sleep,           // power save, indicator off
  output logic                  standby,         // power save, indicator on
  output logic                  ind_level        // static indicator drive
);
  import lcdc_pkg::*;

  // a half period under two cycles leaves no room to count
  if (FAST_CYCLES < 2 || SLOW_CYCLES < 2)
  begin : g_bad_blink
    $error("blink periods too short");
  end

  lcdc_state_t s_q;
  lcdc_state_t s_d;
  logic        cmd_wr;
  logic        data_wr;
  logic        data_rd;
  logic        stat_rd;
  logic [31:0] blink_len;

  assign cmd_wr  = wr_done && !cmd_data_select;
  assign data_wr = wr_done && cmd_data_select;
  assign data_rd = rd_done && cmd_data_select;
  assign stat_rd = rd_done && !cmd_data_select;
  assign blink_len = (s_q.cfg.blink_mode == `LCDC_BLINK_SLOW) ? SLOW_CYCLES : FAST_CYCLES;

  function automatic lcdc_cfg_t cfg_reset();
    lcdc_cfg_t c;
    c          = '0;
    c.contrast = `LCDC_CONTRAST_RST;
    return c;
  endfunction : cfg_reset

  always_comb
  begin
    s_d        = s_q;
    s_d.ram_we = 1'b0;
    if (data_wr)
    begin
      s_d.ram_we     = 1'b1;
      s_d.ram_wdata  = wr_data;
      s_d.cfg.column = s_q.cfg.column + 8'h01;
    end
    if (data_rd)
    begin
      s_d.rd_data = ram_rdata;
      // rmw reads leave the column for the write back
      if (!s_q.cfg.rmw_active)
        s_d.cfg.column = s_q.cfg.column + 8'h01;
    end
    if (stat_rd)
      s_d.rd_data = {1'b0, s_q.cfg.seg_reverse, !s_q.cfg.disp_on, 1'b0, 4'h0};
    if (cmd_wr)
    begin
      case (s_q.mode)
        LCDC_VOL_WAIT:
        begin
          s_d.cfg.contrast = wr_data[5:0];
          s_d.mode         = LCDC_CMD;
        end
        LCDC_IND_WAIT:
        begin
          s_d.cfg.blink_mode = wr_data[1:0];
          s_d.mode           = LCDC_CMD;
        end
        default:
        begin
          casez (wr_data)
            `LCDC_OP_DISP:      s_d.cfg.disp_on = wr_data[0];
            `LCDC_OP_START:     s_d.cfg.start_line = wr_data[5:0];
            `LCDC_OP_PAGE:      s_d.cfg.page = wr_data[3:0];
            `LCDC_OP_COL_HI:    s_d.cfg.column[7:4] = wr_data[3:0];
            `LCDC_OP_COL_LO:    s_d.cfg.column[3:0] = wr_data[3:0];
            `LCDC_OP_ADC:       s_d.cfg.seg_reverse = wr_data[0];
            `LCDC_OP_REVERSE:   s_d.cfg.invert = wr_data[0];
            `LCDC_OP_ENTIRE:    s_d.cfg.entire_on = wr_data[0];
            `LCDC_OP_BIAS:      s_d.cfg.bias_sel = wr_data[0];
            `LCDC_OP_COM_DIR:   s_d.cfg.com_reverse = wr_data[`LCDC_COM_DIR_BIT];
            `LCDC_OP_POWER:     s_d.cfg.power_ctrl = wr_data[2:0];
            `LCDC_OP_RATIO:     s_d.cfg.reg_ratio = wr_data[2:0];
            `LCDC_OP_VOL_ARM:   s_d.mode = LCDC_VOL_WAIT;
            `LCDC_OP_RMW:
            begin
              s_d.cfg.rmw_active = 1'b1;
              s_d.rmw_col        = s_q.cfg.column;
            end
            `LCDC_OP_RMW_END:
            begin
              s_d.cfg.rmw_active = 1'b0;
              s_d.cfg.column     = s_q.rmw_col;
            end
            `LCDC_OP_SW_RESET:
            begin
              // display and panel modes survive the soft reset
              s_d.cfg.start_line = 6'h00;
              s_d.cfg.page       = 4'h0;
              s_d.cfg.column     = 8'h00;
              s_d.cfg.rmw_active = 1'b0;
              s_d.cfg.contrast   = `LCDC_CONTRAST_RST;
              s_d.cfg.test_mode  = 1'b0;
            end
            `LCDC_OP_IND:
            begin
              s_d.cfg.ind_on = wr_data[0];
              if (wr_data[0])
                s_d.mode = LCDC_IND_WAIT;
              else
                s_d.cfg.blink_mode = `LCDC_BLINK_OFF;
            end
            `LCDC_OP_TEST_EXIT: s_d.cfg.test_mode = 1'b0;
            `LCDC_OP_TEST:      s_d.cfg.test_mode = 1'b1;
            default:            ; // nop and undefined codes change nothing
          endcase
        end
      endcase
    end
    case (s_q.cfg.blink_mode)
      `LCDC_BLINK_OFF:
      begin
        s_d.blink_cnt = '0;
        s_d.ind_level = 1'b0;
      end
      `LCDC_BLINK_STEADY:
      begin
        s_d.blink_cnt = '0;
        s_d.ind_level = 1'b1;
      end
      default:
      begin
        if (s_q.blink_cnt >= blink_len - 32'd1)
        begin
          s_d.blink_cnt = '0;
          s_d.ind_level = !s_q.ind_level;
        end
        else
          s_d.blink_cnt = s_q.blink_cnt + 32'd1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || !hw_reset_n)
    begin
      s_q      <= '0;
      s_q.cfg  <= cfg_reset();
      s_q.mode <= LCDC_CMD;
    end
    else
      s_q <= s_d;
  end

  assign cfg       = s_q.cfg;
  assign rd_data   = s_q.rd_data;
  assign ram_we    = s_q.ram_we;
  assign ram_wdata = s_q.ram_wdata;
  assign ram_page  = s_q.cfg.page;
  assign ram_col   = s_d.ram_we ? s_q.cfg.column : s_q.cfg.column - {7'h00, s_q.ram_we};
  assign ind_level = s_q.ind_level;
  // power save is display off plus entire display on
  assign sleep   = !s_q.cfg.disp_on && s_q.cfg.entire_on && !s_q.cfg.ind_on;
  assign standby = !s_q.cfg.disp_on && s_q.cfg.entire_on && s_q.cfg.ind_on;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !hw_reset_n);

  sequence s_cmd(logic [7:0] v);
    cmd_wr && wr_data == v && s_q.mode == LCDC_CMD;
  endsequence

  property p_test_enter;
    cmd_wr && wr_data[7:4] == 4'hf && wr_data != 8'hf0 && s_q.mode == LCDC_CMD |=> cfg.test_mode;
  endproperty
  a_test_enter: assert property (p_test_enter) else $error("test mode not entered");

  property p_test_exit;
    s_cmd(8'hf0) or s_cmd(8'he2) |=> !cfg.test_mode;
  endproperty
  a_test_exit: assert property (p_test_exit) else $error("test mode not left");

  property p_disp;
    cmd_wr && wr_data[7:1] == 7'h57 && s_q.mode == LCDC_CMD |=> cfg.disp_on == $past(wr_data[0]);
  endproperty
  a_disp: assert property (p_disp) else $error("display on/off wrong");

  property p_start;
    cmd_wr && wr_data[7:6] == 2'b01 && s_q.mode == LCDC_CMD |=> cfg.start_line == $past(wr_data[5:0]);
  endproperty
  a_start: assert property (p_start) else $error("start line wrong");

  property p_status;
    stat_rd |=> rd_data[3:0] == 4'h0 && rd_data[5] == !cfg.disp_on;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_data_wr;
    data_wr |=> ram_we && ram_wdata == $past(wr_data) ##1 !ram_we || $past(data_wr);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write lost");

  sequence s_vol_value;
    s_q.mode == LCDC_VOL_WAIT && cmd_wr;
  endsequence

  property p_vol_arm;
    s_cmd(8'h81) |=> s_q.mode == LCDC_VOL_WAIT;
  endproperty
  a_vol_arm: assert property (p_vol_arm) else $error("contrast not armed");

  property p_contrast;
    s_vol_value |=> cfg.contrast == $past(wr_data[5:0]) && s_q.mode == LCDC_CMD;
  endproperty
  a_contrast: assert property (p_contrast) else $error("contrast not stored");

  property p_vol_lock;
    s_vol_value |=> $stable(cfg.disp_on) && $stable(cfg.page);
  endproperty
  a_vol_lock: assert property (p_vol_lock) else $error("command taken while armed");

  property p_rmw_read;
    cfg.rmw_active && data_rd && !data_wr |=> $stable(cfg.column);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read moved column");

  property p_save;
    (sleep || standby) |-> !cfg.disp_on && cfg.entire_on && (standby == cfg.ind_on);
  endproperty
  a_save: assert property (p_save) else $error("power save state wrong");

  property p_page;
    cmd_wr && wr_data[7:4] == 4'hb && s_q.mode == LCDC_CMD |=> cfg.page == $past(wr_data[3:0]);
  endproperty
  a_page: assert property (p_page) else $error("page address wrong");

  property p_col_hi;
    cmd_wr && wr_data[7:4] == 4'h1 && s_q.mode == LCDC_CMD |=> cfg.column[7:4] == $past(wr_data[3:0]);
  endproperty
  a_col_hi: assert property (p_col_hi) else $error("column high nibble wrong");

  property p_com_dir;
    cmd_wr && wr_data[7:4] == 4'hc && s_q.mode == LCDC_CMD |=> cfg.com_reverse == $past(wr_data[3]);
  endproperty
  a_com_dir: assert property (p_com_dir) else $error("common direction wrong");

  property p_blink_val;
    s_q.mode == LCDC_IND_WAIT && cmd_wr |=> cfg.blink_mode == $past(wr_data[1:0]) && s_q.mode == LCDC_CMD;
  endproperty
  a_blink_val: assert property (p_blink_val) else $error("blink mode not stored");

  property p_steady;
    cfg.blink_mode == `LCDC_BLINK_STEADY |=> ind_level;
  endproperty
  a_steady: assert property (p_steady) else $error("steady indicator dark");

  property p_dark;
    cfg.blink_mode == `LCDC_BLINK_OFF |=> !ind_level;
  endproperty
  a_dark: assert property (p_dark) else $error("indicator lit while off");
endmodule : lcdc_cmd_decoder

// ---- rtl/lcdc_pkg.sv ----
package lcdc_pkg;
  typedef enum logic [1:0] {LCDC_CMD, LCDC_VOL_WAIT, LCDC_IND_WAIT} lcdc_mode_t;

  typedef struct packed {
    logic       disp_on;
    logic [5:0] start_line;
    logic [3:0] page;
    logic [7:0] column;
    logic       seg_reverse;
    logic       invert;
    logic       entire_on;
    logic       bias_sel;
    logic       com_reverse;
    logic [2:0] power_ctrl;
    logic [2:0] reg_ratio;
    logic [5:0] contrast;
    logic       ind_on;
    logic [1:0] blink_mode;
    logic       rmw_active;
    logic       test_mode;
  } lcdc_cfg_t;

  typedef struct packed {
    lcdc_cfg_t  cfg;
    lcdc_mode_t mode;
    logic [7:0] rmw_col;
    logic [7:0] rd_data;
    logic       ram_we;
    logic [7:0] ram_wdata;
    logic [31:0] blink_cnt;
    logic       ind_level;
  } lcdc_state_t;
endpackage : lcdc_pkg

// ---- rtl/lcdc_regs.svh ----
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH
// command byte patterns, casez wildcards mark ignored bits
`define LCDC_OP_DISP      8'b1010_111?
`define LCDC_OP_START     8'b01??_????
`define LCDC_OP_PAGE      8'b1011_????
`define LCDC_OP_COL_HI    8'b0001_????
`define LCDC_OP_COL_LO    8'b0000_????
`define LCDC_OP_ADC       8'b1010_000?
`define LCDC_OP_REVERSE   8'b1010_011?
`define LCDC_OP_ENTIRE    8'b1010_010?
`define LCDC_OP_BIAS      8'b1010_001?
`define LCDC_OP_RMW       8'he0
`define LCDC_OP_RMW_END   8'hee
`define LCDC_OP_SW_RESET  8'he2
`define LCDC_OP_NOP       8'he3
`define LCDC_OP_COM_DIR   8'b1100_????
`define LCDC_OP_POWER     8'b0010_1???
`define LCDC_OP_RATIO     8'b0010_0???
`define LCDC_OP_VOL_ARM   8'h81
`define LCDC_OP_IND       8'b1010_110?
`define LCDC_OP_TEST_EXIT 8'hf0
`define LCDC_OP_TEST      8'b1111_????
// reset values and field positions
`define LCDC_CONTRAST_RST 6'h20
`define LCDC_COM_DIR_BIT  3
`define LCDC_BLINK_OFF    2'h0
`define LCDC_BLINK_FAST   2'h1
`define LCDC_BLINK_SLOW   2'h2
`define LCDC_BLINK_STEADY 2'h3
// blink half periods
`define LCDC_BLINK_FAST_MS 500
`define LCDC_BLINK_SLOW_MS 1000
`define LCDC_CLK_KHZ       200000
`endif
